// ---- core/sri_pkg.sv ----
// package for the session register i2c target: constants and types
// assumes a 7-bit i2c address and an eight-byte session block
package sri_pkg;
  localparam logic [6:0] SRI_TARGET_ADDR_RST = 7'h55; // arbitrary default
  localparam logic [7:0] SRI_BLOCK_ADDR      = 8'hFE;
  localparam logic [7:0] SRI_REG_COUNT       = 8'h08;
  localparam int         SRI_IDX_W           = 3;
  localparam logic [7:0] SRI_SESS_RST        = 8'h00;
  localparam logic [3:0] SRI_ACK_BIT         = 4'h8;
  localparam int         SRI_RW_POS          = 0;

  typedef enum logic [2:0] {
    SRI_PH_ADDR,
    SRI_PH_BLOCK,
    SRI_PH_INDEX,
    SRI_PH_MASK,
    SRI_PH_DATA,
    SRI_PH_SEND,
    SRI_PH_IDLE
  } sri_phase_t;
endpackage : sri_pkg

// ---- core/sri_sync.sv ----
// two-flop synchroniser for a level from another clock domain
// assumes the input is glitch free relative to its own domain
`timescale 1ns/100ps
`default_nettype none
module sri_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sri_sync
`default_nettype wire

// ---- core/sri_target.sv ----
// i2c target giving access to the eight-byte session register block
// assumes scl is the link clock; sda appears as in, out, output enable
// Overview of operation
// - start, address with write bit; device acks matching address.
// - next byte must be block address FEh; device acks it.
// - then a register index 00h..07h; device acks it.
// - for reads, stop after the index; device keeps the index.
// - new start, address with read bit; device acks, sends byte.
// - write sends mask after index; only mask-one bits change.
// - one data byte follows the mask, acked, then stop.
// - ack address only on match; otherwise release bus, ignore.
// - sda sampled on scl rising edge; master changes it on low.
`timescale 1ns/100ps
`default_nettype none
module sri_target
  import sri_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = sri_pkg::SRI_TARGET_ADDR_RST
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [63:0]     session_regs,
  output logic            write_done
);
  import sri_pkg::*;

  // link domain: start/stop detection on scl-high sda edges
  logic        start_tog_r;
  logic        stop_tog_r;
  logic        scl_rst_n;

  // sda falling while scl high marks start
  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tog_r <= 1'b0;
    end else if (scl) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_tog_r <= 1'b0;
    end else if (scl) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // only a start restarts the byte framing on scl; a stop does not
  logic        start_ack_r;
  logic        stop_ack_r;
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      start_ack_r <= 1'b0;
      stop_ack_r  <= 1'b0;
    end else begin
      start_ack_r <= start_tog_r;
      stop_ack_r  <= stop_tog_r;
    end
  end
  assign scl_rst_n = rst_n;

  // bit engine on scl: rising edge samples, falling edge drives
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  sri_phase_t  phase_r;
  logic        rw_r;
  logic [7:0]  index_r;
  logic [7:0]  mask_r;
  logic        wr_tog_r;
  logic [7:0]  wr_data_r;
  logic [7:0]  wr_mask_r;
  logic [7:0]  wr_index_r;
  logic        ack_now_r;
  logic [7:0]  tx_r;
  logic [7:0]  rd_byte;
  logic        new_frame;

  assign new_frame = (start_ack_r != start_tog_r);

  function automatic logic [7:0] sel_byte(input logic [63:0] v,
                                          input logic [7:0]  idx);
    sel_byte = v[idx[SRI_IDX_W-1:0]*8 +: 8];
  endfunction : sel_byte

  always_ff @(posedge scl or negedge scl_rst_n) begin
    if (!scl_rst_n) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      phase_r   <= SRI_PH_IDLE;
      rw_r      <= 1'b0;
      index_r   <= 8'h00;
      mask_r    <= 8'h00;
      wr_tog_r  <= 1'b0;
      wr_data_r <= 8'h00;
      wr_mask_r <= 8'h00;
      wr_index_r <= 8'h00;
    end else if (new_frame) begin
      // first bit after a start is address bit 6
      bit_cnt_r <= 4'h1;
      shift_r   <= {7'h00, sda_in};
      phase_r   <= SRI_PH_ADDR;
    end else if (phase_r != SRI_PH_IDLE) begin
      if (bit_cnt_r == SRI_ACK_BIT) begin
        bit_cnt_r <= 4'h0;
        unique case (phase_r)
          SRI_PH_ADDR: begin
            if (shift_r[7:1] != TARGET_ADDR) begin
              phase_r <= SRI_PH_IDLE;
            end else begin
              rw_r    <= shift_r[SRI_RW_POS];
              phase_r <= shift_r[SRI_RW_POS] ? SRI_PH_SEND
                                             : SRI_PH_BLOCK;
            end
          end
          SRI_PH_BLOCK: begin
            phase_r <= (shift_r == SRI_BLOCK_ADDR) ? SRI_PH_INDEX
                                                   : SRI_PH_IDLE;
          end
          SRI_PH_INDEX: begin
            index_r <= shift_r;
            phase_r <= SRI_PH_MASK;
          end
          SRI_PH_MASK: begin
            mask_r  <= shift_r;
            phase_r <= SRI_PH_DATA;
          end
          SRI_PH_DATA: begin
            if (index_r < SRI_REG_COUNT) begin
              wr_data_r  <= shift_r;
              wr_mask_r  <= mask_r;
              wr_index_r <= index_r;
              wr_tog_r   <= ~wr_tog_r;
            end
            phase_r <= SRI_PH_IDLE;
          end
          SRI_PH_SEND: begin
            // one byte only; master acks, then stop
            phase_r <= SRI_PH_IDLE;
          end
          default: phase_r <= SRI_PH_IDLE;
        endcase
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        shift_r   <= {shift_r[6:0], sda_in};
      end
    end
  end

  // falling edge: ack slot and read data drive
  assign rd_byte = sel_byte(session_regs, index_r);
  always_ff @(negedge scl or negedge scl_rst_n) begin
    if (!scl_rst_n) begin
      ack_now_r <= 1'b0;
      tx_r      <= 8'h00;
      sda_oe    <= 1'b0;
    end else begin
      ack_now_r <= 1'b0;
      sda_oe    <= 1'b0;
      if (bit_cnt_r == SRI_ACK_BIT && phase_r != SRI_PH_IDLE
          && !(phase_r == SRI_PH_SEND && rw_r)) begin
        if (phase_r != SRI_PH_ADDR || shift_r[7:1] == TARGET_ADDR) begin
          if (phase_r != SRI_PH_BLOCK || shift_r == SRI_BLOCK_ADDR) begin
            sda_oe    <= 1'b1;
            ack_now_r <= 1'b1;
          end
        end
        if (phase_r == SRI_PH_ADDR && shift_r[SRI_RW_POS]) begin
          tx_r <= rd_byte;
        end
      end else if (phase_r == SRI_PH_SEND && bit_cnt_r < SRI_ACK_BIT) begin
        // msb leaves as the ack slot closes; count 8 releases for the
        // master's ack
        sda_oe <= ~tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b1};
      end
    end
  end
  assign sda_out = 1'b0;

  // crossing of the write event into clk domain via toggle
  logic wr_tog_s;
  logic wr_tog_d_r;
  sri_sync #(.W(1)) u_wr_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (wr_tog_r),
    .q     (wr_tog_s)
  );

  logic wr_evt;
  assign wr_evt = wr_tog_s ^ wr_tog_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tog_d_r <= 1'b0;
      write_done <= 1'b0;
    end else begin
      wr_tog_d_r <= wr_tog_s;
      write_done <= wr_evt;
    end
  end

  // write data is held stable in the scl domain until the next write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      session_regs <= {8{SRI_SESS_RST}};
    end else if (wr_evt) begin
      for (int i = 0; i < 8; i++) begin
        if (wr_index_r[SRI_IDX_W-1:0] == i[SRI_IDX_W-1:0]) begin
          session_regs[i*8 +: 8] <= (session_regs[i*8 +: 8] & ~wr_mask_r)
                                  | (wr_data_r & wr_mask_r);
        end
      end
    end
  end

  // stop never closes a phase here; its detector is kept for visibility
  logic unused_ok;
  assign unused_ok = stop_ack_r ^ ack_now_r;

  property p_masked_write;
    @(posedge clk) disable iff (!rst_n)
    wr_evt |=> ((sel_byte(session_regs, wr_index_r) & ~wr_mask_r)
                == (sel_byte($past(session_regs), wr_index_r)
                    & ~wr_mask_r));
  endproperty
  a_masked_write: assert property (p_masked_write)
    else $error("unmasked bits changed");

  property p_write_value;
    @(posedge clk) disable iff (!rst_n)
    wr_evt |=> ((sel_byte(session_regs, wr_index_r) & wr_mask_r)
                == (wr_data_r & wr_mask_r));
  endproperty
  a_write_value: assert property (p_write_value)
    else $error("masked bits not written");

  property p_done_pulse;
    @(posedge clk) disable iff (!rst_n)
    wr_evt |=> write_done ##1 !write_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("write_done not a single pulse");

  property p_stable_no_write;
    @(posedge clk) disable iff (!rst_n)
    !wr_evt |=> $stable(session_regs);
  endproperty
  a_stable_no_write: assert property (p_stable_no_write)
    else $error("session changed without write");

  property p_ack_needs_phase;
    @(negedge scl) disable iff (!rst_n)
    (bit_cnt_r == SRI_ACK_BIT && phase_r == SRI_PH_ADDR
     && shift_r[7:1] != TARGET_ADDR) |=> !sda_oe;
  endproperty
  a_ack_needs_phase: assert property (p_ack_needs_phase)
    else $error("acked foreign address");

  property p_ack_match;
    @(negedge scl) disable iff (!rst_n)
    (bit_cnt_r == SRI_ACK_BIT && phase_r == SRI_PH_ADDR
     && shift_r[7:1] == TARGET_ADDR) |=> sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("missing address ack");

  property p_block_ack;
    @(negedge scl) disable iff (!rst_n)
    (bit_cnt_r == SRI_ACK_BIT && phase_r == SRI_PH_BLOCK)
      |=> (sda_oe == ($past(shift_r) == SRI_BLOCK_ADDR));
  endproperty
  a_block_ack: assert property (p_block_ack)
    else $error("block byte ack wrong");

  property p_idle_quiet;
    @(negedge scl) disable iff (!rst_n)
    (phase_r == SRI_PH_IDLE && !new_frame) |=> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("drives sda while idle");

  c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_evt);
  c_read: cover property (@(posedge scl) disable iff (!rst_n)
    phase_r == SRI_PH_SEND);
  c_nomatch: cover property (@(posedge scl) disable iff (!rst_n)
    bit_cnt_r == SRI_ACK_BIT && phase_r == SRI_PH_ADDR
    && shift_r[7:1] != TARGET_ADDR);
endmodule : sri_target
`default_nettype wire

// ---- verif/sri_host_model.sv ----
// i2c bus master model driving the session register target
// assumes sda is resolved in the bench with a pull-up
`timescale 1ns/100ps
`default_nettype none
module sri_host_model (
  output logic      scl,
  input  wire logic sda,
  output logic      sda_oe
);
  localparam int Q = 40;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // sda moves only a quarter period after scl falls
  task automatic bit_out(input logic b);
    sda_oe = ~b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask : bit_out
  task automatic bit_in(output logic b);
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_in
  task automatic start();
    #(4*Q) sda_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(2*Q);
  endtask : stop
  task automatic tx(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(a);
    ack = (a === 1'b0);
  endtask : tx
  task automatic wr(input logic [6:0] a, input logic [7:0] blk, idx, m, d,
                    output logic [4:0] ack);
    start();
    tx({a, 1'b0}, ack[4]);
    tx(blk, ack[3]);
    tx(idx, ack[2]);
    tx(m, ack[1]);
    tx(d, ack[0]);
    stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] idx,
                    output logic [7:0] v, output logic [3:0] ack);
    start();
    tx({a, 1'b0}, ack[3]);
    tx(sri_pkg::SRI_BLOCK_ADDR, ack[2]);
    tx(idx, ack[1]);
    stop();
    start();
    tx({a, 1'b1}, ack[0]);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(1'b0);
    stop();
  endtask : rd
endmodule : sri_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the session register i2c target
// assumes the host model makes scl at 160 ns, unrelated to clk
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sri_pkg::*;
  logic        clk, rst_n, scl, host_oe, sda_oe, sda_out, write_done, sda;
  logic [63:0] session_regs, exp_regs;
  logic [7:0]  m, d, v;
  logic [4:0]  ack;
  logic [3:0]  rack;
  int          n_errors, checks, n_wd, k, w;
  // open drain with pull-up
  assign sda = ~(host_oe | (sda_oe & ~sda_out));
  sri_target #(.TARGET_ADDR(SRI_TARGET_ADDR_RST)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .session_regs(session_regs), .write_done(write_done));
  sri_host_model i_host (.scl(scl), .sda(sda), .sda_oe(host_oe));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) if (write_done === 1'b1) n_wd <= n_wd + 1;
  // expected byte after a masked write: only mask-one bits take data
  function automatic logic [7:0] exp_byte(input logic [7:0] old, mk, dt);
    return (old & ~mk) | (dt & mk);
  endfunction : exp_byte
  task automatic check(input string nm, input logic [63:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // refused access: nothing may change and no pulse may appear
  task automatic refused(input logic [6:0] a, input logic [7:0] blk, idx,
                         input logic [4:0] exp_ack);
    w = n_wd;
    i_host.wr(a, blk, idx, 8'hFF, 8'hA5, ack);
    check("refused acks", 64'(exp_ack), 64'(ack));
    check("refused regs", exp_regs, session_regs);
    check("refused pulse", 64'(w), 64'(n_wd));
  endtask : refused
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    n_errors = 0;
    checks = 0;
    n_wd = 0;
    exp_regs = {8{SRI_SESS_RST}};
    void'($urandom(25323));
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    // keeps every link edge of the host off the clk edges
    #3;
    check("reset regs", exp_regs, session_regs);
    for (int i = 0; i < 20; i++) begin
      k = (i == 2) ? 7 : $urandom_range(7);
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      w = n_wd;
      i_host.wr(SRI_TARGET_ADDR_RST, SRI_BLOCK_ADDR, 8'(k), m, d, ack);
      exp_regs[k*8 +: 8] = exp_byte(exp_regs[k*8 +: 8], m, d);
      check("write acks", 64'h1F, 64'(ack));
      check("write pulse", 64'(w + 1), 64'(n_wd));
      check("write regs", exp_regs, session_regs);
    end
    refused(SRI_TARGET_ADDR_RST ^ 7'h01, SRI_BLOCK_ADDR, 8'h00, 5'h00);
    refused(SRI_TARGET_ADDR_RST, 8'hFD, 8'h00, 5'h10);
    refused(SRI_TARGET_ADDR_RST, SRI_BLOCK_ADDR, 8'h08, 5'h1F);
    for (int i = 0; i < 8; i++) begin
      i_host.rd(SRI_TARGET_ADDR_RST, 8'(i), v, rack);
      check("read acks", 64'hF, 64'(rack));
      check("read byte", 64'(exp_regs[i*8 +: 8]), 64'(v));
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
